// [lin_flag_pkg.sv]
package lin_flag_pkg;

  // ****************************************************************
  // Channel count and read command codes
  // ****************************************************************
  localparam int unsigned NUM_CHANNELS = 2;
  localparam logic [15:0] CMD_READ_LIN1 = 16'h2780;
  localparam logic [15:0] CMD_READ_LIN2 = 16'h2980;

  // ****************************************************************
  // Reset values and flag layout of one channel
  // ****************************************************************
  localparam logic FLAG_RESET_VALUE = 1'b0;
  localparam int unsigned FLAG_BUS_CLAMP  = 0;
  localparam int unsigned FLAG_TERM_GND   = 1;
  localparam int unsigned FLAG_OVERTEMP   = 2;
  localparam int unsigned FLAG_RX_LOW     = 3;
  localparam int unsigned FLAG_RX_HIGH    = 4;
  localparam int unsigned FLAG_TX_DOM     = 5;
  localparam int unsigned FLAG_WAKE_SRC   = 6;
  localparam int unsigned NUM_FLAGS       = 7;

  // Channel operating mode
  typedef enum logic [1:0]
  {
    MODE_NORMAL   = 2'b00,
    MODE_TXRX     = 2'b01,
    MODE_SLEEP    = 2'b11
  } lin_mode_t;

endpackage

// [latched_fault_flag.sv]
// One fault flag: latches on fault, clears on read once fault is gone
module latched_fault_flag
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // Fault condition and read strobe
  input  wire logic fault,
  input  wire logic read_clear,
  // Flag
  output logic      flag_q
);
  import lin_flag_pkg::*;

  logic flag_d;

  // ****************************************************************
  // Next value: set wins over clear, live fault blocks the clear
  // ****************************************************************
  always_comb
  begin
    flag_d = flag_q;
    if (read_clear && !fault)
      flag_d = 1'b0;
    if (fault)
      flag_d = 1'b1;
  end

  // Register
  always_ff @(posedge clock)
  begin
    if (!rstn)
      flag_q <= FLAG_RESET_VALUE;
    else
      flag_q <= flag_d;
  end

endmodule

// [lin_diagnostic_flag_logic.sv]
// Function
// - Watchdog refresh failure flag sets on bad refresh, clears on SPI read.
// - Bus clamp flag sets when channel bus stays dominant past timeout.
// - Bus clamp flag holds until clamp recovered and flag read.
// - State bit reads 1 in transmit/receive mode, else 0.
// - State bit drops on SPI mode change or transmit-dominant failure.
// - Flag read commands leave the state bit untouched.
// - Wake receiver bit is 1 in sleep with wake on, 0 otherwise.
// - With wake receiver bit 0, bus activity is ignored.
// - Flag read commands leave the wake receiver bit untouched.
// - Wake source flag sets on channel wake, clears on SPI read.
// - Termination ground fault latches, clears after recovery plus read.
// - Overtemperature flag clears only below threshold and after read.
// - Receive-low fault latches, clears after recovery plus read.
// - Receive-high fault latches, clears after recovery plus read.
// - Transmit-dominant fault latches, clears after recovery plus read.
// - Pending channel flag shows as that channel's source bit.
module lin_diagnostic_flag_logic
(
  // Clock and reset
  input  wire logic                                    clock,
  input  wire logic                                    rstn,
  // Watchdog
  input  wire logic                                    wd_refresh_fail,
  input  wire logic                                    wd_flag_read,
  output logic                                         wd_fail_flag,
  // Decoded SPI command word, valid for one cycle
  input  wire logic                                    cmd_valid,
  input  wire logic [15:0]                             cmd_word,
  // Per-channel mode requests from SPI
  input  wire logic [lin_flag_pkg::NUM_CHANNELS-1:0]   req_txrx,
  input  wire logic [lin_flag_pkg::NUM_CHANNELS-1:0]   req_sleep,
  input  wire logic [lin_flag_pkg::NUM_CHANNELS-1:0]   sleep_wake_en,
  // Per-channel fault detectors from analog (asynchronous)
  input  wire logic [lin_flag_pkg::NUM_CHANNELS-1:0]   bus_dom_timeout,
  input  wire logic [lin_flag_pkg::NUM_CHANNELS-1:0]   term_gnd_fault,
  input  wire logic [lin_flag_pkg::NUM_CHANNELS-1:0]   thermal_over,
  input  wire logic [lin_flag_pkg::NUM_CHANNELS-1:0]   rx_low_fault,
  input  wire logic [lin_flag_pkg::NUM_CHANNELS-1:0]   rx_high_fault,
  input  wire logic [lin_flag_pkg::NUM_CHANNELS-1:0]   tx_dom_fault,
  input  wire logic [lin_flag_pkg::NUM_CHANNELS-1:0]   bus_wake_activity,
  // Per-channel flag outputs
  output logic [lin_flag_pkg::NUM_CHANNELS-1:0]        bus_clamp_flag,
  output logic [lin_flag_pkg::NUM_CHANNELS-1:0]        term_gnd_flag,
  output logic [lin_flag_pkg::NUM_CHANNELS-1:0]        overtemp_flag,
  output logic [lin_flag_pkg::NUM_CHANNELS-1:0]        rx_low_flag,
  output logic [lin_flag_pkg::NUM_CHANNELS-1:0]        rx_high_flag,
  output logic [lin_flag_pkg::NUM_CHANNELS-1:0]        tx_dom_flag,
  output logic [lin_flag_pkg::NUM_CHANNELS-1:0]        wake_src_flag,
  output logic [lin_flag_pkg::NUM_CHANNELS-1:0]        lin_state_bit,
  output logic [lin_flag_pkg::NUM_CHANNELS-1:0]        lin_wake_receiver_bit,
  // Summary source bits for the fixed status word
  output logic [lin_flag_pkg::NUM_CHANNELS-1:0]        lin_source_bit,
  output logic                                         lin_group_bit
);
  import lin_flag_pkg::*;

  // Every channel carries the same flag set; widths follow the package
  localparam int unsigned NC = NUM_CHANNELS;
  localparam int unsigned FW = NUM_FLAGS * NUM_CHANNELS;

  // ****************************************************************
  // Decode of the channel flag read command
  // ****************************************************************
  // Used per channel, so kept as a function
  // Only two codes exist, one for each channel
  function automatic logic is_read_cmd(input logic [15:0] word,
                                       input int unsigned ch);
    logic hit;
    hit = 1'b0;
    if (ch == 0)
      hit = (word == CMD_READ_LIN1);
    else
      hit = (word == CMD_READ_LIN2);
    return hit;
  endfunction

  // ****************************************************************
  // Two-flop synchronisers for all analog fault and wake inputs
  // ****************************************************************
  // Every fault reaches its flag three edges after it rises. A fault
  // that comes and goes between two edges may be missed, so detectors
  // are expected to stretch their pulses to at least one clock cycle.
  logic [FW-1:0] raw_in;
  logic [FW-1:0] sync1_q;
  logic [FW-1:0] sync1_d;
  logic [FW-1:0] sync2_q;
  logic [FW-1:0] sync2_d;

  assign raw_in = {bus_wake_activity, tx_dom_fault, rx_high_fault,
                   rx_low_fault, thermal_over, term_gnd_fault,
                   bus_dom_timeout};

  // Next values of the synchroniser chain
  always_comb
  begin
    sync1_d = raw_in;
    sync2_d = sync1_q;
  end

  // Synchroniser registers
  // Reset clears both stages so no stale fault survives reset
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // Synchronised per-channel slices
  // Packing order of raw_in must match these slices
  logic [NC-1:0] s_dom;
  logic [NC-1:0] s_term;
  logic [NC-1:0] s_temp;
  logic [NC-1:0] s_rxl;
  logic [NC-1:0] s_rxh;
  logic [NC-1:0] s_txd;
  logic [NC-1:0] s_wake;

  assign s_dom  = sync2_q[NC-1:0];
  assign s_term = sync2_q[2*NC-1:NC];
  assign s_temp = sync2_q[3*NC-1:2*NC];
  assign s_rxl  = sync2_q[4*NC-1:3*NC];
  assign s_rxh  = sync2_q[5*NC-1:4*NC];
  assign s_txd  = sync2_q[6*NC-1:5*NC];
  assign s_wake = sync2_q[7*NC-1:6*NC];

  // ****************************************************************
  // Watchdog refresh failure flag
  // ****************************************************************
  logic wd_flag_q;
  logic wd_flag_d;

  // Watchdog pulses come from this clock domain, so no synchroniser
  // Set wins over a read in the same cycle
  always_comb
  begin
    wd_flag_d = wd_flag_q;
    if (wd_flag_read)
      wd_flag_d = 1'b0;
    if (wd_refresh_fail)
      wd_flag_d = 1'b1;
  end

  // Register
  always_ff @(posedge clock)
  begin
    if (!rstn)
      wd_flag_q <= FLAG_RESET_VALUE;
    else
      wd_flag_q <= wd_flag_d;
  end

  assign wd_fail_flag = wd_flag_q;

  // ****************************************************************
  // Per-channel logic
  // ****************************************************************
  // One copy of every flag and mode register for each channel
  logic [NC-1:0] rd_clr;
  logic [NC-1:0] any_flag;

  genvar ch;
  generate
    for (ch = 0; ch < NC; ch++)
    begin : g_ch
      lin_mode_t mode_q;
      lin_mode_t mode_d;
      logic      wake_en_q;
      logic      wake_en_d;
      logic      wsrc_q;
      logic      wsrc_d;

      // Read strobe aimed only at this channel
      // Any other command word leaves every flag of this channel alone
      assign rd_clr[ch] = cmd_valid && is_read_cmd(cmd_word, ch);

      // Latched fault flags, each with its own recovery condition
      // A read that meets a fault still present is lost; the host
      // must read again once the fault has gone
      latched_fault_flag u_clamp
      (
        .clock      (clock),
        .rstn       (rstn),
        .fault      (s_dom[ch]),
        .read_clear (rd_clr[ch]),
        .flag_q     (bus_clamp_flag[ch])
      );
      latched_fault_flag u_term
      (
        .clock      (clock),
        .rstn       (rstn),
        .fault      (s_term[ch]),
        .read_clear (rd_clr[ch]),
        .flag_q     (term_gnd_flag[ch])
      );
      latched_fault_flag u_temp
      (
        .clock      (clock),
        .rstn       (rstn),
        .fault      (s_temp[ch]),
        .read_clear (rd_clr[ch]),
        .flag_q     (overtemp_flag[ch])
      );
      latched_fault_flag u_rxl
      (
        .clock      (clock),
        .rstn       (rstn),
        .fault      (s_rxl[ch]),
        .read_clear (rd_clr[ch]),
        .flag_q     (rx_low_flag[ch])
      );
      latched_fault_flag u_rxh
      (
        .clock      (clock),
        .rstn       (rstn),
        .fault      (s_rxh[ch]),
        .read_clear (rd_clr[ch]),
        .flag_q     (rx_high_flag[ch])
      );
      latched_fault_flag u_txd
      (
        .clock      (clock),
        .rstn       (rstn),
        .fault      (s_txd[ch]),
        .read_clear (rd_clr[ch]),
        .flag_q     (tx_dom_flag[ch])
      );

      // Mode, wake enable and wake source next values
      // Sleep outranks tx/rx when both are asked for in one cycle
      // A stuck transmit pin also refuses a fresh tx/rx request
      always_comb
      begin
        mode_d    = mode_q;
        wake_en_d = wake_en_q;
        wsrc_d    = wsrc_q;
        // Reads never touch mode or wake enable: and
        if (req_sleep[ch])
        begin
          mode_d    = MODE_SLEEP;
          wake_en_d = sleep_wake_en[ch];
        end
        else if (req_txrx[ch])
        begin
          mode_d    = MODE_TXRX;
          wake_en_d = 1'b0;
        end
        // Transmit stuck dominant forces the channel out of tx/rx
        if (s_txd[ch] && mode_d == MODE_TXRX)
          mode_d = MODE_NORMAL;
        if (rd_clr[ch])
          wsrc_d = 1'b0;
        // Wake activity outside sleep is ignored, not kept for later
        // Wake only counts while the receiver is armed
        if (s_wake[ch] && wake_en_q && mode_q == MODE_SLEEP)
          wsrc_d = 1'b1;                  // and
      end

      // Registers
      always_ff @(posedge clock)
      begin
        if (!rstn)
        begin
          mode_q    <= MODE_NORMAL;
          wake_en_q <= FLAG_RESET_VALUE;
          wsrc_q    <= FLAG_RESET_VALUE;
        end
        else
        begin
          mode_q    <= mode_d;
          wake_en_q <= wake_en_d;
          wsrc_q    <= wsrc_d;
        end
      end

      assign lin_state_bit[ch]         = (mode_q == MODE_TXRX);
      assign lin_wake_receiver_bit[ch] = wake_en_q;
      assign wake_src_flag[ch]         = wsrc_q;

      // Summary of any pending event flag of this channel
      assign any_flag[ch] = bus_clamp_flag[ch] | term_gnd_flag[ch] |
                            overtemp_flag[ch] | rx_low_flag[ch] |
                            rx_high_flag[ch] | tx_dom_flag[ch] |
                            wsrc_q;
    end
  endgenerate

  // ****************************************************************
  // Source bits for the fixed status word
  // ****************************************************************
  // Live state bits are left out: they report no pending event
  // The group bit lets the host skip both channel reads when idle
  assign lin_source_bit = any_flag;
  assign lin_group_bit  = |any_flag;

endmodule

// [lin_flag_asserts.sv]
// ****************
// Flag logic checks
// ****************
module lin_flag_asserts
  import lin_flag_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rstn,
  // Watchdog
  input wire logic        wd_refresh_fail,
  input wire logic        wd_flag_read,
  input wire logic        wd_fail_flag,
  // Commands and mode requests
  input wire logic        cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic [1:0]  req_txrx,
  input wire logic [1:0]  req_sleep,
  input wire logic [1:0]  sleep_wake_en,
  // Fault detectors
  input wire logic [1:0]  bus_dom_timeout,
  input wire logic [1:0]  term_gnd_fault,
  input wire logic [1:0]  tx_dom_fault,
  // Flags and state
  input wire logic [1:0]  bus_clamp_flag,
  input wire logic [1:0]  term_gnd_flag,
  input wire logic [1:0]  wake_src_flag,
  input wire logic [1:0]  lin_state_bit,
  input wire logic [1:0]  lin_wake_receiver_bit,
  input wire logic [1:0]  lin_source_bit,
  input wire logic        lin_group_bit
);
  import lin_flag_pkg::*;
  // Single domain, so clock and reset gating are shared
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_wd_set; wd_refresh_fail |=> wd_fail_flag; endproperty
  a_wd_set: assert property (p_wd_set) else $error("wd set");
  property p_wd_clr;
    wd_fail_flag && wd_flag_read && !wd_refresh_fail |=> !wd_fail_flag;
  endproperty
  a_wd_clr: assert property (p_wd_clr) else $error("wd clear");
  // Four samples cover the two synchroniser stages plus the latch
  property p_clamp; bus_dom_timeout[0] [*4] |=> bus_clamp_flag[0]; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp set");
  property p_hold;
    bus_clamp_flag[1] && !(cmd_valid && cmd_word == CMD_READ_LIN2)
      |=> bus_clamp_flag[1];
  endproperty
  a_hold: assert property (p_hold) else $error("clamp hold");
  property p_keep;
    term_gnd_fault[0] [*3] ##0 (term_gnd_flag[0] && cmd_valid
      && cmd_word == CMD_READ_LIN1) |=> term_gnd_flag[0];
  endproperty
  a_keep: assert property (p_keep) else $error("fault kept");
  property p_txrx;
    (!tx_dom_fault[0]) [*3] ##0 (req_txrx[0] && !req_sleep[0])
      |=> lin_state_bit[0];
  endproperty
  a_txrx: assert property (p_txrx) else $error("state set");
  property p_sleep;
    req_sleep[1] |=> !lin_state_bit[1]
      && lin_wake_receiver_bit[1] == $past(sleep_wake_en[1]);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep");
  property p_read_rt;
    (!tx_dom_fault[0]) [*3] ##0 (cmd_valid && !req_txrx[0] && !req_sleep[0])
      |=> $stable(lin_state_bit[0]) && $stable(lin_wake_receiver_bit[0]);
  endproperty
  a_read_rt: assert property (p_read_rt)
    else $error("live");
  property p_wake_off;
    !lin_wake_receiver_bit[1] && !wake_src_flag[1] |=> !wake_src_flag[1];
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake");
  property p_source;
    lin_group_bit == |lin_source_bit && ((bus_clamp_flag | term_gnd_flag
      | wake_src_flag) & ~lin_source_bit) == 2'h0;
  endproperty
  a_source: assert property (p_source) else $error("source");
endmodule

bind lin_diagnostic_flag_logic lin_flag_asserts u_chk (
  .clock, .rstn, .wd_refresh_fail, .wd_flag_read, .wd_fail_flag,
  .cmd_valid, .cmd_word, .req_txrx, .req_sleep, .sleep_wake_en,
  .bus_dom_timeout, .term_gnd_fault, .tx_dom_fault, .bus_clamp_flag,
  .term_gnd_flag, .wake_src_flag, .lin_state_bit, .lin_wake_receiver_bit,
  .lin_source_bit, .lin_group_bit
);

// [lin_host_model.sv]
// ****************
// Host issuing flag read commands
// ****************
module lin_host_model
  import lin_flag_pkg::*;
(
  // Clock
  input  wire logic   clock,
  // Read request from the bench
  input  wire logic   rd_go,
  input  wire logic   rd_ch,
  // Command toward the device
  output logic        cmd_valid = 1'h0,
  output logic [15:0] cmd_word = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle word churns so a stale command code never lingers on the bus
  always @(negedge clock)
  begin
    cmd_valid <= rd_go;
    if (rd_go)
      cmd_word <= rd_ch ? CMD_READ_LIN2 : CMD_READ_LIN1;
    else
      cmd_word <= 16'($urandom);
  end
endmodule

// [lin_diagnostic_flag_logic_tb_top.sv]
module lin_diagnostic_flag_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lin_flag_pkg::*;
  // ****************
  // Stimulus, expectations and checking
  // ****************
  logic        clock = 1'h0;
  logic        rstn = 1'h0;
  logic [1:0]  wd = 2'h0;
  logic [1:0]  req_txrx = 2'h0;
  logic [1:0]  req_sleep = 2'h0;
  logic [1:0]  sleep_wake_en = 2'h0;
  logic        rd_go = 1'h0;
  logic        rd_ch = 1'h0;
  wire         cmd_valid;
  wire  [15:0] cmd_word;
  wire  [21:0] got;
  // Faults in flag order, wake activity last; expected flags alike
  logic [1:0]  flt [7] = '{default: 2'h0};
  logic [1:0]  ef [7] = '{default: 2'h0};
  logic [1:0]  est = 2'h0;
  logic [1:0]  ewk = 2'h0;
  logic        ewd = 1'h0;
  logic [21:0] exp_q [$];
  int          failures = 0;
  int          checks = 0;

  // 40 MHz clock
  initial forever #12.5 clock = ~clock;

  lin_diagnostic_flag_logic u_dut (
    .clock, .rstn, .wd_refresh_fail(wd[0]), .wd_flag_read(wd[1]),
    .wd_fail_flag(got[21]), .cmd_valid, .cmd_word, .req_txrx, .req_sleep,
    .sleep_wake_en, .bus_dom_timeout(flt[0]), .term_gnd_fault(flt[1]),
    .thermal_over(flt[2]), .rx_low_fault(flt[3]), .rx_high_fault(flt[4]),
    .tx_dom_fault(flt[5]), .bus_wake_activity(flt[6]),
    .bus_clamp_flag(got[20:19]), .term_gnd_flag(got[18:17]),
    .overtemp_flag(got[16:15]), .rx_low_flag(got[14:13]),
    .rx_high_flag(got[12:11]), .tx_dom_flag(got[10:9]),
    .wake_src_flag(got[8:7]), .lin_state_bit(got[6:5]),
    .lin_wake_receiver_bit(got[4:3]), .lin_source_bit(got[2:1]),
    .lin_group_bit(got[0]));

  lin_host_model u_host (.clock, .rd_go, .rd_ch, .cmd_valid, .cmd_word);

  task automatic step(int n);
    repeat (n) @(negedge clock);
  endtask

  // Note the whole expected output picture; summary bits derived here
  task automatic chk();
    logic [1:0] s;
    s = ef[0] | ef[1] | ef[2] | ef[3] | ef[4] | ef[5] | ef[6];
    exp_q.push_back({ewd, ef[0], ef[1], ef[2], ef[3], ef[4], ef[5], ef[6],
                     est, ewk, s, |s});
  endtask

  task automatic compare(string name, logic [21:0] e, logic [21:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  // Host drives the read at the next falling edge; the device takes it at the rising edge half a cycle later
  task automatic host_read(int ch);
    rd_ch <= ch[0];
    rd_go <= 1'h1;
    step(1);
    rd_go <= 1'h0;
    step(1);
  endtask

  // Blocking at the falling edge keeps clear of the sampling edge
  task automatic pulse(ref logic [1:0] s, input int c);
    s[c] = 1'h1;
    step(1);
    s[c] = 1'h0;
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // All outputs are registers or gates on registers, so 1 ns after the falling edge they
  // settle on what the last rising edge launched, clear of any race
  always @(negedge clock)
  begin
    #1;
    if (exp_q.size() > 0)
      compare("flags", exp_q.pop_front(), got);
  end

  initial
  begin
    void'($urandom(93));
    step(8);
    rstn <= 1'h1;
    step(1);
    chk();
    for (int f = 0; f < 6; f++)
      for (int c = 0; c < 2; c++)
      begin
        pulse(req_txrx, c);
        {est[c], ewk[c]} = 2'h2;
        chk();
        flt[f][c] = 1'h1;
        step(4);
        ef[f][c] = 1'h1;
        est[c] &= (f != 5);
        chk();
        host_read(c);
        chk();
        flt[f][c] = 1'h0;
        step(3);
        chk();
        // Fault gone: only a read of the other channel must not clear
        host_read(1 - c);
        chk();
        host_read(c);
        ef[f][c] = 1'h0;
        chk();
        sleep_wake_en[c] = 1'($urandom);
        pulse(req_sleep, c);
        {est[c], ewk[c]} = {1'h0, sleep_wake_en[c]};
        chk();
        host_read(c);
        chk();
        flt[6][c] = 1'h1;
        step(4);
        flt[6][c] = 1'h0;
        ef[6][c] = ewk[c];
        chk();
        step(3);
        host_read(c);
        ef[6][c] = 1'h0;
        chk();
        pulse(wd, 0);
        ewd = 1'h1;
        chk();
        pulse(wd, 1);
        ewd = 1'h0;
        chk();
      end
    // Bounded drain of the last notes
    for (int i = 0; i < 4 && exp_q.size() > 0; i++)
      step(1);
    if (exp_q.size() > 0)
      failures++;
    final_report();
  end
endmodule
